// ---- logic/bwt_defines.vh ----
`ifndef BWT_DEFINES_VH
`define BWT_DEFINES_VH

// ----------------------------------------------------------------
// Register indices (byte address is four times the index)
// ----------------------------------------------------------------
`define BWT_IDX_W          12
`define BWT_IDX_RSTAT      12'h285
`define BWT_IDX_ICFG       12'h286
`define BWT_IDX_CTRL       12'h28C
`define BWT_IDX_IRQST      12'h2A0
`define BWT_IDX_IRQMSK     12'h2A1

// ----------------------------------------------------------------
// Control register fields
// ----------------------------------------------------------------
`define BWT_FLAG_BIT       7
`define BWT_MODE_HI        6
`define BWT_MODE_LO        5
`define BWT_EN_BIT         4
`define BWT_PER_HI         3
`define BWT_PER_LO         0

`define BWT_MODE_TIMER     2'h0
`define BWT_MODE_RESET     2'h1
`define BWT_MODE_INT       2'h2
`define BWT_MODE_DUAL      2'h3

`define BWT_MODE_RST_VAL   2'h0
`define BWT_PER_RST_VAL    4'h0

// ----------------------------------------------------------------
// Routing, reset status and interrupt status fields
// ----------------------------------------------------------------
`define BWT_ROUTE_HI       1
`define BWT_ROUTE_LO       0
`define BWT_ROUTE_OFF      2'h0
`define BWT_ROUTE_LINE5    2'h1
`define BWT_RSTFLAG_BIT    0

`define BWT_IRQ_W          3
`define BWT_IRQ_TIMEOUT    0
`define BWT_IRQ_WDREQ      1
`define BWT_IRQ_HARDRST    2

// ----------------------------------------------------------------
// Timing
// ----------------------------------------------------------------
`define BWT_CLK_PERIOD_NS  50
`define BWT_TICK_US        125000
`define BWT_TICK_CYCLES    (`BWT_TICK_US * 1000 / `BWT_CLK_PERIOD_NS)
`define BWT_HRST_CYCLES    8

`endif

// ---- logic/bwt_board_watchdog.v ----
// Notes on behaviour
// - Bit 7 of the control register is a sticky expired flag cleared by writing 1.
// - Bits 6 to 5 pick timer, reset, interrupt or dual-stage mode as 00, 01, 10, 11.
// - Bit 4 enables when idle, retriggers when running, and reads 1 while running.
// - Bits 3 to 0 give a period of 0.125 s times two to the power of the code.
// - After power-on the watchdog is idle and takes no action until enabled.
// - While running, writes that would disable it or change its setup are ignored.
// - While running, each write of 1 to bit 4 restarts the count.
// - On expiry the flag is set in every mode in the same cycle as the mode action.
// - Timer mode expiry stops the watchdog; restart needs the flag cleared before or with the enable.
// - Reset mode expiry forces a hard reset and the flag survives it.
// - Interrupt mode expiry requests an interrupt if routed and stops the watchdog.
// - Dual-stage first expiry requests an interrupt if routed and reloads the count itself.
// - Dual-stage second expiry without a retrigger forces a hard reset.
// - The routing field gates the interrupt: 00 off, 01 line 5, others reserved.
// - A watchdog reset sets a reset status bit cleared by writing 1.
//
// The APB slave port was decided locally.
`timescale 1ns/1ns

`include "bwt_defines.vh"

module bwt_board_watchdog #(
  parameter TICK_CYCLES = `BWT_TICK_CYCLES,
  parameter TICK_W      = 22,
  parameter HRST_CYCLES = `BWT_HRST_CYCLES,
  parameter HRST_W      = 4
) (
  // Clock and power-on reset
  input  wire        clock,
  input  wire        rst_n,
  // APB slave
  input  wire [13:0] paddr,
  input  wire        psel,
  input  wire        penable,
  input  wire        pwrite,
  input  wire [31:0] pwdata,
  input  wire [3:0]  pstrb,
  output wire [31:0] prdata,
  output wire        pready,
  output wire        pslverr,
  // Board side
  output wire        irq,
  output wire        hardResetReq,
  output wire        watchdogEnabled
);

  // ----------------------------------------------------------------
  // Constants
  // ----------------------------------------------------------------
  localparam [31:0] TICK_LAST32 = TICK_CYCLES - 1;
  localparam [31:0] HRST_LOAD32 = HRST_CYCLES;

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  reg                  enabled_q;
  reg [1:0]            mode_q;
  reg [3:0]            period_q;
  reg                  expired_q;
  reg                  stage_q;
  reg [TICK_W-1:0]     tickCnt_q;
  reg [15:0]           periodCnt_q;
  reg [1:0]            route_q;
  reg                  rstFlag_q;
  reg [`BWT_IRQ_W-1:0] irqSt_q;
  reg [`BWT_IRQ_W-1:0] irqMask_q;
  reg [HRST_W-1:0]     hrstCnt_q;
  reg [31:0]           prdata_q;
  reg                  ready_q;

  // ----------------------------------------------------------------
  // Bus decode
  // ----------------------------------------------------------------
  wire [`BWT_IDX_W-1:0] idx;
  wire                  hitCtrl;
  wire                  hitRstat;
  wire                  hitIcfg;
  wire                  hitIrqSt;
  wire                  hitIrqMsk;
  wire                  hitAny;
  wire                  access;
  wire                  wrAcc;
  wire                  wrCtrl;
  wire                  wrRstat;
  wire                  wrIcfg;
  wire                  wrIrqSt;
  wire                  wrIrqMsk;

  assign idx       = paddr[13:2];
  assign hitCtrl   = (idx == `BWT_IDX_CTRL);
  assign hitRstat  = (idx == `BWT_IDX_RSTAT);
  assign hitIcfg   = (idx == `BWT_IDX_ICFG);
  assign hitIrqSt  = (idx == `BWT_IDX_IRQST);
  assign hitIrqMsk = (idx == `BWT_IDX_IRQMSK);
  assign hitAny    = hitCtrl | hitRstat | hitIcfg | hitIrqSt | hitIrqMsk;

  // No wait state: pready comes in the first access cycle, and read data
  // is captured from the setup address so that prdata comes from a flop
  assign access    = psel & penable & ready_q;
  assign wrAcc     = access & pwrite & pstrb[0] & hitAny;
  assign wrCtrl    = wrAcc & hitCtrl;
  assign wrRstat   = wrAcc & hitRstat;
  assign wrIcfg    = wrAcc & hitIcfg;
  assign wrIrqSt   = wrAcc & hitIrqSt;
  assign wrIrqMsk  = wrAcc & hitIrqMsk;

  assign pready    = psel & penable & ready_q;
  assign pslverr   = psel & penable & ready_q & ~hitAny;
  assign prdata    = prdata_q;

  // ----------------------------------------------------------------
  // Watchdog events
  // ----------------------------------------------------------------
  wire        tick;
  wire [15:0] periodLast;
  wire        timeout;
  wire        kick;
  wire        enReq;
  wire        isDual;
  wire        stopMode;
  wire        hardFire;
  wire        irqFire;

  // Wide prescaler keeps the period counter at 16 bits
  assign tick       = (tickCnt_q == TICK_LAST32[TICK_W-1:0]);
  assign periodLast = (16'h0001 << period_q) - 16'h0001;
  assign timeout    = enabled_q & tick & (periodCnt_q == periodLast);
  // Retrigger while running
  assign kick       = wrCtrl & pwdata[`BWT_EN_BIT] & enabled_q;
  // Enable refused while the expired flag would stay set
  assign enReq      = wrCtrl & pwdata[`BWT_EN_BIT] & ~enabled_q &
                      (~expired_q | pwdata[`BWT_FLAG_BIT]);
  assign isDual     = (mode_q == `BWT_MODE_DUAL);
  assign stopMode   = (mode_q == `BWT_MODE_TIMER) |
                      (mode_q == `BWT_MODE_INT);
  assign hardFire   = timeout & ((mode_q == `BWT_MODE_RESET) |
                      (isDual & stage_q));
  assign irqFire    = timeout & (route_q == `BWT_ROUTE_LINE5) &
                      ((mode_q == `BWT_MODE_INT) |
                       (isDual & ~stage_q));

  // ----------------------------------------------------------------
  // Prescaler and period counter
  // ----------------------------------------------------------------
  // An expiry wins over a kick in the same cycle; both reload from zero
  always @(posedge clock) begin
    if (!rst_n) begin
      tickCnt_q   <= {TICK_W{1'b0}};
      periodCnt_q <= 16'h0000;
    end else if (!enabled_q || timeout || kick || enReq) begin
      // Every expiry reloads from zero; stopping modes also drop enable
      tickCnt_q   <= {TICK_W{1'b0}};
      periodCnt_q <= 16'h0000;
    end else if (tick) begin
      tickCnt_q   <= {TICK_W{1'b0}};
      periodCnt_q <= periodCnt_q + 16'h0001;
    end else begin
      tickCnt_q   <= tickCnt_q + {{(TICK_W-1){1'b0}}, 1'b1};
    end
  end

  // ----------------------------------------------------------------
  // Control register
  // ----------------------------------------------------------------
  always @(posedge clock) begin
    if (!rst_n) begin
      enabled_q <= 1'b0;
      mode_q    <= `BWT_MODE_RST_VAL;
      period_q  <= `BWT_PER_RST_VAL;
    end else begin
      // Setup is frozen while running; a zero in bit 4 never disables
      if (wrCtrl && !enabled_q) begin
        mode_q   <= pwdata[`BWT_MODE_HI:`BWT_MODE_LO];
        period_q <= pwdata[`BWT_PER_HI:`BWT_PER_LO];
      end
      if (enReq) begin
        enabled_q <= 1'b1;
      end else if (timeout && stopMode) begin
        enabled_q <= 1'b0;
      end
    end
  end

  // Expiry wins over a clear in the same cycle
  always @(posedge clock) begin
    if (!rst_n) begin
      expired_q <= 1'b0;
    end else if (timeout) begin
      expired_q <= 1'b1;
    end else if (wrCtrl && pwdata[`BWT_FLAG_BIT]) begin
      expired_q <= 1'b0;
    end
  end

  // Dual-stage: set by the first expiry, cleared by the second expiry or by a software retrigger
  always @(posedge clock) begin
    if (!rst_n) begin
      stage_q <= 1'b0;
    end else if (timeout && isDual) begin
      stage_q <= ~stage_q;
    end else if (kick || enReq) begin
      stage_q <= 1'b0;
    end
  end

  // ----------------------------------------------------------------
  // Hard reset request, reset status and routing
  // ----------------------------------------------------------------
  // Only the power-on reset rst_n resets this block, so the flag survives the board reset
  always @(posedge clock) begin
    if (!rst_n) begin
      hrstCnt_q <= {HRST_W{1'b0}};
    end else if (hardFire) begin
      hrstCnt_q <= HRST_LOAD32[HRST_W-1:0];
    end else if (hrstCnt_q != {HRST_W{1'b0}}) begin
      hrstCnt_q <= hrstCnt_q - {{(HRST_W-1){1'b0}}, 1'b1};
    end
  end

  assign hardResetReq = (hrstCnt_q != {HRST_W{1'b0}});

  always @(posedge clock) begin
    if (!rst_n) begin
      rstFlag_q <= 1'b0;
    end else if (hardFire) begin
      rstFlag_q <= 1'b1;
    end else if (wrRstat && pwdata[`BWT_RSTFLAG_BIT]) begin
      rstFlag_q <= 1'b0;
    end
  end

  always @(posedge clock) begin
    if (!rst_n) begin
      route_q <= `BWT_ROUTE_OFF;
    end else if (wrIcfg) begin
      route_q <= pwdata[`BWT_ROUTE_HI:`BWT_ROUTE_LO];
    end
  end

  // ----------------------------------------------------------------
  // Interrupt status and mask
  // ----------------------------------------------------------------
  wire [`BWT_IRQ_W-1:0] irqEvt;
  wire [`BWT_IRQ_W-1:0] irqClr;

  assign irqEvt = {hardFire, irqFire, timeout};
  assign irqClr = wrIrqSt ? pwdata[`BWT_IRQ_W-1:0] : {`BWT_IRQ_W{1'b0}};

  always @(posedge clock) begin
    if (!rst_n) begin
      irqSt_q   <= {`BWT_IRQ_W{1'b0}};
      irqMask_q <= {`BWT_IRQ_W{1'b0}};
    end else begin
      // New events win over a write-one clear
      irqSt_q <= irqEvt | (irqSt_q & ~irqClr);
      if (wrIrqMsk) begin
        irqMask_q <= pwdata[`BWT_IRQ_W-1:0];
      end
    end
  end

  assign irq             = |(irqSt_q & irqMask_q);
  assign watchdogEnabled = enabled_q;

  // ----------------------------------------------------------------
  // Read data
  // ----------------------------------------------------------------
  reg [31:0] rdData;

  always @* begin
    rdData = 32'h00000000;
    if (hitCtrl) begin
      rdData[`BWT_FLAG_BIT]              = expired_q;
      rdData[`BWT_MODE_HI:`BWT_MODE_LO]  = mode_q;
      rdData[`BWT_EN_BIT]                = enabled_q;
      rdData[`BWT_PER_HI:`BWT_PER_LO]    = period_q;
    end else if (hitRstat) begin
      rdData[`BWT_RSTFLAG_BIT]           = rstFlag_q;
    end else if (hitIcfg) begin
      rdData[`BWT_ROUTE_HI:`BWT_ROUTE_LO] = route_q;
    end else if (hitIrqSt) begin
      rdData[`BWT_IRQ_W-1:0]             = irqSt_q;
    end else if (hitIrqMsk) begin
      rdData[`BWT_IRQ_W-1:0]             = irqMask_q;
    end
  end

  // Capture in the setup cycle so prdata comes from a flop
  always @(posedge clock) begin
    if (!rst_n) begin
      prdata_q <= 32'h00000000;
      ready_q  <= 1'b0;
    end else begin
      ready_q <= psel & ~penable;
      if (psel && !penable && !pwrite) begin
        prdata_q <= rdData;
      end
    end
  end

endmodule // bwt_board_watchdog

// ---- tb/bwt_board_watchdog_checker.sv ----
`timescale 1ns/1ns
`include "bwt_defines.vh"
module bwt_board_watchdog_checker (
  // Clock and reset
  input wire        clock,
  input wire        rst_n,
  // APB
  input wire [13:0] paddr,
  input wire        psel,
  input wire        penable,
  input wire        pwrite,
  input wire [31:0] pwdata,
  input wire [3:0]  pstrb,
  input wire [31:0] prdata,
  input wire        pready,
  input wire        pslverr,
  // Board side
  input wire        irq,
  input wire        hardResetReq,
  input wire        watchdogEnabled
);
  wire [11:0] idx    = paddr[13:2];
  wire        mapped = idx == `BWT_IDX_CTRL || idx == `BWT_IDX_RSTAT ||
                       idx == `BWT_IDX_ICFG || idx == `BWT_IDX_IRQST ||
                       idx == `BWT_IDX_IRQMSK;
  wire        wrDone = psel && penable && pready && pwrite && pstrb[0];
  wire        ctlWr  = wrDone && idx == `BWT_IDX_CTRL;

  default clocking @(posedge clock); endclocking
  default disable iff (!rst_n);

  a_wait_state: assert property ((psel && !penable) ##1 (psel && penable)
    |-> pready) else $error("no pready in first access cycle");
  a_ready_follow: assert property (pready |=> !pready)
    else $error("pready held past the access cycle");
  a_err_unmapped: assert property (pready |-> pslverr == !mapped)
    else $error("pslverr wrong for address");
  a_read_upper: assert property (pready && !pwrite |-> prdata[31:8] == 24'h0)
    else $error("upper read bits not zero");
  a_idle_release: assert property ($rose(rst_n) |->
    !watchdogEnabled && !irq && !hardResetReq) else $error("busy after reset");
  a_enable_held: assert property (ctlWr && watchdogEnabled |=>
    watchdogEnabled) else $error("write disabled running watchdog");
  a_enable_cause: assert property ($rose(watchdogEnabled) |->
    $past(ctlWr && pwdata[4])) else $error("enable without write");
  a_reset_pulse: assert property ($rose(hardResetReq) |->
    hardResetReq[*8] ##1 !hardResetReq) else $error("bad hard reset length");
  a_reset_cause: assert property ($rose(hardResetReq) |->
    $past(watchdogEnabled)) else $error("hard reset while idle");
  a_irq_cause: assert property ($rose(irq) |->
    $past(watchdogEnabled) || $past(wrDone)) else $error("irq without cause");
endmodule // bwt_board_watchdog_checker

bind bwt_board_watchdog bwt_board_watchdog_checker i_bwt_board_watchdog_checker (
  .clock(clock), .rst_n(rst_n), .paddr(paddr), .psel(psel),
  .penable(penable), .pwrite(pwrite), .pwdata(pwdata), .pstrb(pstrb),
  .prdata(prdata), .pready(pready), .pslverr(pslverr), .irq(irq),
  .hardResetReq(hardResetReq), .watchdogEnabled(watchdogEnabled));

// ---- tb/bwt_board_watchdog_test.sv ----
`timescale 1ns/1ns
`include "bwt_defines.vh"
`define CHK(a, b) begin checked++; if ((a) !== (b)) begin fails++; \
  $display("ERROR t=%0t got=%0h exp=%0h", $time, (a), (b)); end end
module bwt_board_watchdog_test;
  localparam [13:0] A_CTRL = {`BWT_IDX_CTRL, 2'b00};
  localparam [13:0] A_RST  = {`BWT_IDX_RSTAT, 2'b00};
  localparam [13:0] A_CFG  = {`BWT_IDX_ICFG, 2'b00};
  localparam [13:0] A_IST  = {`BWT_IDX_IRQST, 2'b00};
  localparam [13:0] A_MSK  = {`BWT_IDX_IRQMSK, 2'b00};
  localparam [13:0] A_BAD  = 14'hA34;
  reg         clock   = 1'b0;
  reg         rst_n   = 1'b0;
  reg  [13:0] paddr   = 14'h0;
  reg         psel    = 1'b0;
  reg         penable = 1'b0;
  reg         pwrite  = 1'b0;
  reg  [31:0] pwdata  = 32'h0;
  reg  [3:0]  pstrb   = 4'hF;
  reg  [3:0]  strb    = 4'hF;
  wire [31:0] prdata;
  wire        pready, pslverr, irq, hardResetReq, watchdogEnabled;
  reg  [31:0] rd;
  reg         err;
  int         fails   = 0;
  int         checked = 0;

  always #25 clock = ~clock;

  // Short tick keeps the longest period used here at 64 cycles
  bwt_board_watchdog #(.TICK_CYCLES(4)) i_bwt_board_watchdog (
    .clock(clock), .rst_n(rst_n), .paddr(paddr), .psel(psel),
    .penable(penable), .pwrite(pwrite), .pwdata(pwdata), .pstrb(pstrb),
    .prdata(prdata), .pready(pready), .pslverr(pslverr), .irq(irq),
    .hardResetReq(hardResetReq), .watchdogEnabled(watchdogEnabled));

  // ----------------------------------------------------------------
  // Bus and expectation helpers
  // ----------------------------------------------------------------
  task automatic apb(input [13:0] a, input w, input [31:0] d);
    int n;
    n = 0;
    @(posedge clock);
    psel <= 1'b1;
    paddr <= a;
    pwrite <= w;
    pwdata <= d;
    pstrb <= strb;
    @(posedge clock);
    penable <= 1'b1;
    do begin
      @(posedge clock);
      n++;
    end while (pready !== 1'b1 && n < 20);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    if (n >= 20) fails++;
    #1;
  endtask

  task automatic wr(input [13:0] a, input [7:0] d);
    apb(a, 1'b1, ($urandom << 8) | {24'h0, d});
  endtask

  task automatic rdchk(input [13:0] a, input [31:0] e);
    apb(a, 1'b0, $urandom);
    `CHK(rd, e)
  endtask

  // Select 0 waits for stop, 1 for hard reset, 2 for irq
  task automatic wait_evt(input int s, input int n);
    int c;
    c = 0;
    do begin
      @(posedge clock);
      c++;
    end while (!(s == 0 ? watchdogEnabled === 1'b0 : s == 1 ?
               hardResetReq === 1'b1 : irq === 1'b1) && c < n + 9);
    `CHK(c >= n && c <= n + 2, 1'b1)
  endtask

  task automatic pwr_on;
    @(posedge clock);
    rst_n <= 1'b0;
    repeat (8) @(posedge clock);
    rst_n <= 1'b1;
  endtask

  function automatic [7:0] ctl(input f, input [1:0] m, input e, input [3:0] p);
    ctl = {f, m, e, p};
  endfunction

  // Timeout always; routed request in interrupt and dual; hard reset in
  // reset and dual
  function automatic [31:0] ist(input [1:0] m, input [1:0] r);
    ist = {29'h0, m[0], m[1] && r == `BWT_ROUTE_LINE5, 1'b1};
  endfunction

  task automatic end_of_test;
    $display("fails=%0d checked=%0d", fails, checked);
    if (fails == 0 && checked > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask

  initial begin
    #(50 * 20000);
    fails++;
    end_of_test;
  end

  // ----------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------
  initial begin
    reg [1:0] m;
    reg [1:0] r;
    reg [3:0] p;
    int       i;
    int       n;
    void'($urandom(32'hE055));
    pwr_on;
    rdchk(A_CTRL, 32'h0);
    rdchk(A_RST, 32'h0);
    rdchk(A_IST, 32'h0);
    apb(A_BAD, 1'b0, 32'h0);
    `CHK({err, rd}, 33'h100000000)
    // A write without the low byte strobe must leave the register alone
    strb = 4'h0;
    wr(A_MSK, 8'h07);
    strb = 4'hF;
    rdchk(A_MSK, 32'h0);
    for (i = 0; i < 5; i++) begin
      m = (i == 4) ? 2'h2 : i[1:0];
      r = (i == 4) ? `BWT_ROUTE_OFF : `BWT_ROUTE_LINE5;
      p = ($urandom % 2) ? 4'h4 : 4'h3;
      n = 4 << p;
      pwr_on;
      wr(A_CFG, {6'h0, r});
      wr(A_MSK, m[0] ? 8'h07 : 8'h00);
      wr(A_CTRL, ctl(1'b0, m, 1'b0, p));
      wr(A_CTRL, ctl(1'b0, m, 1'b1, p));
      `CHK(watchdogEnabled, 1'b1)
      wr(A_CTRL, ctl(1'b0, ~m, 1'b0, ~p));
      rdchk(A_CTRL, ctl(1'b0, m, 1'b1, p));
      repeat (18) wr(A_CTRL, ctl(1'b0, m, 1'b1, p));
      `CHK(watchdogEnabled, 1'b1)
      if (!m[0]) begin
        wait_evt(0, n);
        rdchk(A_CTRL, ctl(1'b1, m, 1'b0, p));
        rdchk(A_IST, ist(m, r));
        `CHK(irq, 1'b0)
        wr(A_MSK, 8'h07);
        `CHK(irq, 1'b1)
        wr(A_CTRL, ctl(1'b0, m, 1'b1, p));
        `CHK(watchdogEnabled, 1'b0)
        wr(A_CTRL, 8'h80);
        rdchk(A_CTRL, 32'h0);
        wr(A_IST, 8'h07);
        rdchk(A_IST, 32'h0);
        `CHK(irq, 1'b0)
        wr(A_CTRL, ctl(1'b0, m, 1'b1, p));
        `CHK(watchdogEnabled, 1'b1)
      end else begin
        wait_evt(m[1] ? 2 : 1, n);
        `CHK({hardResetReq, watchdogEnabled}, {~m[1], 1'b1})
        if (m[1]) wait_evt(1, n);
        rdchk(A_CTRL, ctl(1'b1, m, 1'b1, p));
        rdchk(A_RST, 32'h1);
        rdchk(A_IST, ist(m, r));
        wr(A_RST, 8'h01);
        rdchk(A_RST, 32'h0);
      end
    end
    end_of_test;
  end
endmodule // bwt_board_watchdog_test
